//--- rtl/crfa_regfile.sv
// register file with operand address generator for the core pipeline
// assumes the pipeline holds only legal selects and one write per register per cycle
`timescale 1ns/10ps
module crfa_regfile
	import crfa_pkg::*;
(
	input wire logic core_clk_in,
	input wire logic rst_b_in,
	input wire logic [31:0] vec_pc_in,
	input wire logic [31:0] vec_sp_in,
	input wire logic vec_valid_in,
	output logic ready_out,
	input wire logic [3:0] rd_a_sel_in,
	input wire logic [3:0] rd_b_sel_in,
	input wire logic r0_only_in,
	output logic [31:0] rd_a_out,
	output logic [31:0] rd_b_out,
	input wire logic gr_we_in,
	input wire logic [3:0] gr_wsel_in,
	input wire logic [31:0] gr_wdata_in,
	input wire logic ctl_we_in,
	input wire logic [1:0] ctl_sel_in,
	input wire logic [31:0] ctl_wdata_in,
	input wire logic sys_we_in,
	input wire logic [1:0] sys_sel_in,
	input wire logic [31:0] sys_wdata_in,
	output logic [31:0] ctl_rdata_out,
	output logic [31:0] sys_rdata_out,
	output logic [31:0] processing_state_reg_out,
	input wire logic [31:0] pc_next_in,
	input wire logic pc_load_in,
	output logic [31:0] program_counter_out,
	input wire logic ag_req_in,
	input wire logic [3:0] ag_mode_in,
	input wire logic [3:0] ag_reg_in,
	input wire logic [1:0] ag_size_in,
	input wire logic [1:0] ag_br_in,
	input wire logic [11:0] ag_disp_in,
	output logic [31:0] ag_addr_out,
	output logic [31:0] ag_operand_out,
	output logic ag_valid_out,
	input wire logic exc_push_in,
	input wire logic exc_pop_in,
	output logic [31:0] exc_stack_addr_out,
	input wire logic [7:0] vec_num_in,
	output logic [31:0] vec_fetch_addr_out
);
	typedef struct packed {
		logic [GREG_N-1:0][WORD_W-1:0] gr;
		logic [31:0] processing_state_reg;
		logic [31:0] global_base_reg;
		logic [31:0] vector_base_reg;
		logic [31:0] mac_high_reg;
		logic [31:0] mac_low_reg;
		logic [31:0] procedure_return_reg;
		logic [31:0] program_counter;
		logic [31:0] ag_addr;
		logic [31:0] ag_operand;
		logic ag_valid;
		crfa_state_e st;
	} crfa_state_s;

	crfa_state_s cur;
	crfa_state_s next_cur;

	// byte step for a given access size
	function automatic logic [31:0] crfa_step(input logic [1:0] sz);
		case (sz)
			CRFA_SZ_B: crfa_step = 32'h00000001;
			CRFA_SZ_W: crfa_step = 32'h00000002;
			default: crfa_step = 32'h00000004;
		endcase
	endfunction : crfa_step

	// pc as instructions see it
	function automatic logic [31:0] crfa_pc_view(input logic [31:0] pc);
		crfa_pc_view = pc + PC_AHEAD;
	endfunction : crfa_pc_view

	// general register read with pc-free select
	function automatic logic [31:0] crfa_gread(input crfa_state_s s, input logic [3:0] sel);
		crfa_gread = s.gr[sel];
	endfunction : crfa_gread

	// next-state logic
	always_comb begin
		logic [31:0] rn;
		logic [31:0] r0;
		logic [31:0] sp;
		rn = crfa_gread(cur, ag_reg_in);
		r0 = crfa_gread(cur, IDX_REG);
		sp = crfa_gread(cur, SP_REG);
		next_cur = cur;
		next_cur.ag_valid = 1'b0;
		case (cur.st)
			CRFA_ST_LDPC: begin
				if (vec_valid_in) begin
					next_cur.program_counter = vec_pc_in;
					next_cur.st = CRFA_ST_LDSP;
				end
			end
			CRFA_ST_LDSP: begin
				next_cur.gr[SP_REG] = vec_sp_in;
				next_cur.st = CRFA_ST_RUN;
			end
			CRFA_ST_RUN: begin
				// pipeline writes
				if (gr_we_in) begin
					next_cur.gr[gr_wsel_in] = gr_wdata_in;
				end
				if (ctl_we_in) begin
					case (ctl_sel_in)
						CRFA_CR_SR: next_cur.processing_state_reg = ctl_wdata_in & SR_WMASK;
						CRFA_CR_GBR: next_cur.global_base_reg = ctl_wdata_in;
						CRFA_CR_VBR: next_cur.vector_base_reg = ctl_wdata_in;
						default: next_cur.processing_state_reg = cur.processing_state_reg;
					endcase
				end
				if (sys_we_in) begin
					case (sys_sel_in)
						CRFA_SY_MAC_HIGH_REG: next_cur.mac_high_reg = sys_wdata_in;
						CRFA_SY_MAC_LOW_REG: next_cur.mac_low_reg = sys_wdata_in;
						CRFA_SY_PR: next_cur.procedure_return_reg = sys_wdata_in;
						default: next_cur.program_counter = sys_wdata_in;
					endcase
				end
				if (pc_load_in) begin
					next_cur.program_counter = pc_next_in;
				end
				// exception stacking through the stack pointer
				if (exc_push_in) begin
					next_cur.gr[SP_REG] = sp - crfa_step(CRFA_SZ_L);
				end else if (exc_pop_in) begin
					next_cur.gr[SP_REG] = sp + crfa_step(CRFA_SZ_L);
				end
				// address generation, result registered
				if (ag_req_in) begin
					next_cur.ag_valid = 1'b1;
					next_cur.ag_operand = rn;
					next_cur.ag_addr = rn;
					case (ag_mode_in)
						CRFA_AM_REG: next_cur.ag_addr = ZERO_W;
						CRFA_AM_IND: next_cur.ag_addr = rn;
						CRFA_AM_POSTINC: begin
							next_cur.ag_addr = rn;
							next_cur.gr[ag_reg_in] = rn + crfa_step(ag_size_in);
						end
						CRFA_AM_PREDEC: begin
							next_cur.ag_addr = rn - crfa_step(ag_size_in);
							next_cur.gr[ag_reg_in] = rn - crfa_step(ag_size_in);
						end
						CRFA_AM_DISP4: next_cur.ag_addr = rn + {28'h0000000, ag_disp_in[3:0]};
						CRFA_AM_IDXIND: next_cur.ag_addr = r0 + rn;
						CRFA_AM_GBDISP: next_cur.ag_addr = cur.global_base_reg + {24'h000000, ag_disp_in[7:0]};
						CRFA_AM_GBIDX: next_cur.ag_addr = cur.global_base_reg + r0;
						CRFA_AM_PCDISP: next_cur.ag_addr = crfa_pc_view(cur.program_counter)
							+ {24'h000000, ag_disp_in[7:0]};
						CRFA_AM_PCBR: begin
							case (ag_br_in)
								CRFA_BR_D8: next_cur.ag_addr = crfa_pc_view(cur.program_counter)
									+ {{24{ag_disp_in[7]}}, ag_disp_in[7:0]};
								CRFA_BR_D12: next_cur.ag_addr = crfa_pc_view(cur.program_counter)
									+ {{20{ag_disp_in[11]}}, ag_disp_in};
								default: next_cur.ag_addr = crfa_pc_view(cur.program_counter) + rn;
							endcase
						end
						CRFA_AM_IMM: begin
							next_cur.ag_addr = ZERO_W;
							next_cur.ag_operand = {{24{ag_disp_in[7]}}, ag_disp_in[7:0]};
						end
						default: next_cur.ag_valid = 1'b0;
					endcase
				end
			end
			default: next_cur.st = CRFA_ST_LDPC;
		endcase
	end

	// state register
	always_ff @(posedge core_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			cur <= '0;
			cur.processing_state_reg <= SR_RESET;
			cur.vector_base_reg <= VBR_RESET;
			cur.st <= CRFA_ST_LDPC;
		end else begin
			cur <= next_cur;
		end
	end

	// read ports
	always_comb begin
		rd_a_out = r0_only_in ? cur.gr[IDX_REG] : cur.gr[rd_a_sel_in];
		rd_b_out = cur.gr[rd_b_sel_in];
		case (ctl_sel_in)
			CRFA_CR_SR: ctl_rdata_out = cur.processing_state_reg;
			CRFA_CR_GBR: ctl_rdata_out = cur.global_base_reg;
			CRFA_CR_VBR: ctl_rdata_out = cur.vector_base_reg;
			default: ctl_rdata_out = ZERO_W;
		endcase
		case (sys_sel_in)
			CRFA_SY_MAC_HIGH_REG: sys_rdata_out = cur.mac_high_reg;
			CRFA_SY_MAC_LOW_REG: sys_rdata_out = cur.mac_low_reg;
			CRFA_SY_PR: sys_rdata_out = cur.procedure_return_reg;
			default: sys_rdata_out = crfa_pc_view(cur.program_counter);
		endcase
	end

	// stack and vector addresses
	assign exc_stack_addr_out = exc_pop_in ? cur.gr[SP_REG] : cur.gr[SP_REG] - crfa_step(CRFA_SZ_L);
	assign vec_fetch_addr_out = cur.vector_base_reg + {22'h000000, vec_num_in, 2'h0};
	assign ready_out = (cur.st == CRFA_ST_RUN);
	assign processing_state_reg_out = cur.processing_state_reg;
	assign program_counter_out = cur.program_counter;
	assign ag_addr_out = cur.ag_addr;
	assign ag_operand_out = cur.ag_operand;
	assign ag_valid_out = cur.ag_valid;
endmodule : crfa_regfile

//--- shared/crfa_pkg.sv
// package for the core register file and operand address generator
// assumes the pipeline drives all requests on core_clk_in, one cycle each
package crfa_pkg;
	localparam int WORD_W = 32;
	localparam int GREG_N = 16;
	localparam logic [3:0] IDX_REG = 4'h0;
	localparam logic [3:0] SP_REG = 4'hF;
	localparam logic [31:0] PC_AHEAD = 32'h00000004;
	localparam logic [31:0] SR_RESET = 32'h000000F0;
	localparam logic [31:0] SR_WMASK = 32'h000003F3;
	localparam logic [31:0] VBR_RESET = 32'h00000000;
	localparam logic [31:0] ZERO_W = 32'h00000000;
	localparam logic [31:0] PRESET_ZERO = 32'h00000000;
	// addressing modes, eleven in all
	typedef enum logic [3:0] {
		CRFA_AM_REG = 4'h0, CRFA_AM_IND = 4'h1, CRFA_AM_POSTINC = 4'h2, CRFA_AM_PREDEC = 4'h3,
		CRFA_AM_DISP4 = 4'h4, CRFA_AM_IDXIND = 4'h5, CRFA_AM_GBDISP = 4'h6, CRFA_AM_GBIDX = 4'h7,
		CRFA_AM_PCDISP = 4'h8, CRFA_AM_PCBR = 4'h9, CRFA_AM_IMM = 4'hA
	} crfa_mode_e;
	// pc relative branch source
	typedef enum logic [1:0] {CRFA_BR_D8 = 2'h0, CRFA_BR_D12 = 2'h1, CRFA_BR_REG = 2'h2} crfa_br_e;
	// access size steps for increment/decrement
	typedef enum logic [1:0] {CRFA_SZ_B = 2'h0, CRFA_SZ_W = 2'h1, CRFA_SZ_L = 2'h2} crfa_size_e;
	// control register select
	typedef enum logic [1:0] {CRFA_CR_SR = 2'h0, CRFA_CR_GBR = 2'h1, CRFA_CR_VBR = 2'h2} crfa_ctl_e;
	// system register select
	typedef enum logic [1:0] {CRFA_SY_MAC_HIGH_REG = 2'h0, CRFA_SY_MAC_LOW_REG = 2'h1, CRFA_SY_PR = 2'h2, CRFA_SY_PC = 2'h3} crfa_sys_e;
	// reset load sequence, one-hot
	typedef enum logic [2:0] {CRFA_ST_LDPC = 3'b001, CRFA_ST_LDSP = 3'b010, CRFA_ST_RUN = 3'b100} crfa_state_e;
endpackage : crfa_pkg

//--- test/crfa_vec_model.sv
// vector table model: hands the reset pc and sp words to the register file
// assumes the core clock and the active low reset of the block
`timescale 1ns/10ps
module crfa_vec_model #(
	parameter logic [31:0] PC_VAL = 32'h00000400,
	parameter logic [31:0] SP_VAL = 32'h0000FFF0,
	parameter int LAT = 3
) (
	input wire logic core_clk_in,
	input wire logic rst_b_in,
	output logic [31:0] vec_pc_out,
	output logic [31:0] vec_sp_out,
	output logic vec_valid_out
);
	logic [3:0] cnt;
	// fetch latency after reset, then the words stay valid
	always_ff @(posedge core_clk_in or negedge rst_b_in) begin
		if (!rst_b_in)
			cnt <= 4'h0;
		else if (cnt != LAT[3:0])
			cnt <= cnt + 4'h1;
	end
	// words read as inverted junk until the fetch completes
	assign vec_valid_out = (cnt == LAT[3:0]);
	assign vec_pc_out = vec_valid_out ? PC_VAL : ~PC_VAL;
	assign vec_sp_out = vec_valid_out ? SP_VAL : ~SP_VAL;
endmodule : crfa_vec_model

//--- test/crfa_regfile_checker.sv
// assertions on the register file ports
// assumes one clock domain and the active low asynchronous reset
`timescale 1ns/10ps
module crfa_regfile_checker
	import crfa_pkg::*;
(
	input wire logic core_clk_in,
	input wire logic rst_b_in,
	input wire logic ready_out,
	input wire logic vec_valid_in,
	input wire logic ag_req_in,
	input wire logic [3:0] ag_mode_in,
	input wire logic ag_valid_out,
	input wire logic [31:0] processing_state_reg_out,
	input wire logic [1:0] ctl_sel_in,
	input wire logic [31:0] ctl_rdata_out,
	input wire logic [7:0] vec_num_in,
	input wire logic [31:0] vec_fetch_addr_out,
	input wire logic [1:0] sys_sel_in,
	input wire logic [31:0] sys_rdata_out,
	input wire logic [31:0] program_counter_out,
	input wire logic r0_only_in,
	input wire logic [3:0] rd_b_sel_in,
	input wire logic [31:0] rd_a_out,
	input wire logic [31:0] rd_b_out,
	input wire logic exc_pop_in,
	input wire logic [31:0] exc_stack_addr_out
);
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (!rst_b_in);
	a_valid_on_req: assert property (ready_out && ag_req_in && ag_mode_in <= 4'hA |=> ag_valid_out)
		else $error("address result missing");
	a_valid_has_cause: assert property (ag_valid_out |-> $past(ag_req_in && ready_out))
		else $error("address result without request");
	a_bad_mode_idle: assert property (ag_req_in && ag_mode_in > 4'hA |=> !ag_valid_out)
		else $error("bad mode answered");
	a_state_at_load: assert property (!ready_out |-> processing_state_reg_out == SR_RESET)
		else $error("state register wrong before ready");
	a_state_reserved: assert property ((processing_state_reg_out & ~SR_WMASK) == ZERO_W)
		else $error("reserved state bits set");
	a_ready_after_vec: assert property ($rose(ready_out) |-> $past(vec_valid_in))
		else $error("ready without vector words");
	a_vec_addr: assert property (ctl_sel_in == 2'h2 |-> vec_fetch_addr_out == ctl_rdata_out + {vec_num_in, 2'h0})
		else $error("vector fetch address wrong");
	a_pc_ahead: assert property (sys_sel_in == 2'h3 |-> sys_rdata_out == program_counter_out + PC_AHEAD)
		else $error("pc read not four ahead");
	a_index_forced: assert property (r0_only_in && rd_b_sel_in == IDX_REG |-> rd_a_out == rd_b_out)
		else $error("forced operand not register zero");
	a_stack_addr: assert property (rd_b_sel_in == SP_REG && !exc_pop_in |-> exc_stack_addr_out == rd_b_out - 32'h4)
		else $error("push address wrong");
endmodule : crfa_regfile_checker
bind crfa_regfile crfa_regfile_checker u_chk (.*);

//--- test/tb.sv
// self-checking bench for the register file and address generator
// assumes the vector model answers a few cycles after reset
`timescale 1ns/10ps
module tb;
	import crfa_pkg::*;
	logic core_clk_in = 0, rst_b_in = 0, vec_valid_in, ready_out, r0_only_in = 0, gr_we_in = 0, ctl_we_in = 0;
	logic sys_we_in = 0, pc_load_in = 0, ag_req_in = 0, exc_push_in = 0, exc_pop_in = 0, ag_valid_out;
	logic [31:0] vec_pc_in, vec_sp_in, rd_a_out, rd_b_out, gr_wdata_in = 0, ctl_wdata_in = 0, sys_wdata_in = 0;
	logic [31:0] ctl_rdata_out, sys_rdata_out, processing_state_reg_out, pc_next_in = 0, program_counter_out;
	logic [31:0] ag_addr_out, ag_operand_out, exc_stack_addr_out, vec_fetch_addr_out;
	logic [3:0] rd_a_sel_in = 0, rd_b_sel_in = 0, gr_wsel_in = 0, ag_mode_in = 0, ag_reg_in = 0;
	logic [1:0] ctl_sel_in = 0, sys_sel_in = 0, ag_size_in = 0, ag_br_in = 0;
	logic [11:0] ag_disp_in = 0;
	logic [7:0] vec_num_in = 0;
	int err_total = 0, samples_checked = 0;
	typedef struct {logic [3:0] m; logic [1:0] br; logic [11:0] d; logic op; logic [31:0] e;} crfa_row_s;
	// mode, branch source, displacement, operand result, expected value (r3=3100 r0=100 gbr=8000 pc=400)
	crfa_row_s rows[11] = '{'{4'h1, 2'h0, 12'h000, 1'b0, 32'h00003100}, '{4'h4, 2'h0, 12'h005, 1'b0, 32'h00003105},
		'{4'h5, 2'h0, 12'h000, 1'b0, 32'h00003200}, '{4'h6, 2'h0, 12'h012, 1'b0, 32'h00008012},
		'{4'h7, 2'h0, 12'h000, 1'b0, 32'h00008100}, '{4'h8, 2'h0, 12'h008, 1'b0, 32'h0000040C},
		'{4'h9, 2'h0, 12'h0FE, 1'b0, 32'h00000402}, '{4'h9, 2'h1, 12'h800, 1'b0, 32'hFFFFFC04},
		'{4'h9, 2'h2, 12'h000, 1'b0, 32'h00003504}, '{4'h0, 2'h0, 12'h000, 1'b1, 32'h00003100},
		'{4'hA, 2'h0, 12'h080, 1'b1, 32'hFFFFFF80}};
	crfa_regfile u_dut (.*);
	crfa_vec_model u_vec (.core_clk_in(core_clk_in), .rst_b_in(rst_b_in), .vec_pc_out(vec_pc_in),
		.vec_sp_out(vec_sp_in), .vec_valid_out(vec_valid_in));
	always #12.5 core_clk_in = ~core_clk_in;
	task chk(input logic [31:0] g, input logic [31:0] e);
		samples_checked++;
		if (g !== e) begin
			err_total++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk
	task rd(input logic [3:0] s, input logic [31:0] e);
		rd_b_sel_in = s;
		#1 chk(rd_b_out, e);
	endtask : rd
	task wr(input logic [2:0] we, input logic [3:0] s, input logic [31:0] d);
		@(posedge core_clk_in) #2 {gr_we_in, ctl_we_in, sys_we_in} = we;
		gr_wsel_in = s;
		ctl_sel_in = s[1:0];
		sys_sel_in = s[1:0];
		gr_wdata_in = d;
		ctl_wdata_in = d;
		sys_wdata_in = d;
		@(posedge core_clk_in) #2 {gr_we_in, ctl_we_in, sys_we_in} = 3'h0;
	endtask : wr
	task ag(input logic [3:0] m, input logic [1:0] br, input logic [1:0] sz, input logic [11:0] d);
		@(posedge core_clk_in) #2 ag_req_in = 1;
		ag_mode_in = m;
		ag_reg_in = 4'h3;
		ag_br_in = br;
		ag_size_in = sz;
		ag_disp_in = d;
		@(posedge core_clk_in) #2 ag_req_in = 0;
	endtask : ag
	task wrap_up;
		$display("checked %0d errors %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : wrap_up
	// watchdog
	initial begin
		#20000;
		err_total++;
		wrap_up;
	end
	initial begin
		repeat (6) @(posedge core_clk_in);
		#2 rst_b_in = 1;
		ctl_sel_in = 2'h2;
		#1 chk(processing_state_reg_out, SR_RESET);
		chk(ctl_rdata_out, VBR_RESET);
		for (int i = 0; i < 50 && ready_out !== 1'b1; i++) @(posedge core_clk_in);
		#2 chk(program_counter_out, 32'h00000400);
		rd(SP_REG, 32'h0000FFF0);
		sys_sel_in = 2'h3;
		#1 chk(sys_rdata_out, 32'h00000404);
		@(posedge core_clk_in) #2 exc_push_in = 1;
		#1 chk(exc_stack_addr_out, 32'h0000FFEC);
		@(posedge core_clk_in) #2 exc_push_in = 0;
		rd(SP_REG, 32'h0000FFEC);
		for (int i = 0; i < 16; i++) wr(3'h4, i[3:0], 32'h1000 * i + 32'h100);
		for (int i = 0; i < 16; i++) rd(i[3:0], 32'h1000 * i + 32'h100);
		for (int i = 0; i < 3; i++) wr(3'h1, i[3:0], 32'hA0 + i);
		for (int i = 0; i < 3; i++) begin
			sys_sel_in = i[1:0];
			#1 chk(sys_rdata_out, 32'hA0 + i);
		end
		wr(3'h2, 4'h0, 32'hFFFFFFFF);
		chk(ctl_rdata_out, SR_WMASK);
		wr(3'h2, 4'h2, 32'h00001000);
		vec_num_in = 8'h03;
		#1 chk(vec_fetch_addr_out, 32'h0000100C);
		wr(3'h2, 4'h1, 32'h00008000);
		foreach (rows[i]) begin
			ag(rows[i].m, rows[i].br, 2'h2, rows[i].d);
			chk(rows[i].op ? ag_operand_out : ag_addr_out, rows[i].e);
		end
		ag(4'h2, 2'h0, 2'h2, 12'h000);
		chk(ag_addr_out, 32'h00003100);
		rd(4'h3, 32'h00003104);
		ag(4'h3, 2'h0, 2'h1, 12'h000);
		chk(ag_addr_out, 32'h00003102);
		rd(4'h3, 32'h00003102);
		ag(4'hB, 2'h0, 2'h0, 12'h000);
		chk({31'h0, ag_valid_out}, 32'h0);
		ag(4'h2, 2'h0, 2'h0, 12'h000);
		chk(ag_addr_out, 32'h00003102);
		rd(4'h3, 32'h00003103);
		rd_b_sel_in = IDX_REG;
		r0_only_in = 1;
		rd_a_sel_in = 4'h5;
		#1 chk(rd_a_out, 32'h00000100);
		// pop reads the stack at sp, then sp moves up a word
		@(posedge core_clk_in) #2 exc_pop_in = 1;
		#1 chk(exc_stack_addr_out, 32'h0000F100);
		@(posedge core_clk_in) #2 exc_pop_in = 0;
		rd(SP_REG, 32'h0000F104);
		// pipeline pc load, read back four ahead
		@(posedge core_clk_in) #2 pc_load_in = 1;
		pc_next_in = 32'h00000800;
		@(posedge core_clk_in) #2 pc_load_in = 0;
		chk(program_counter_out, 32'h00000800);
		sys_sel_in = 2'h3;
		#1 chk(sys_rdata_out, 32'h00000804);
		@(posedge core_clk_in) #2;
		wrap_up;
	end
endmodule : tb
